// file: core/gpioc_pkg.sv
// Constants, register map and types of the GPIO pin controller.
// Assumes one group of 32 lines behind an AXI4-Lite slave on aclk.
package gpioc_pkg;
	// ==========================================
	// Sizes
	localparam int unsigned GPIOC_NL = 32;
	localparam int unsigned GPIOC_NEV = 4;
	localparam int unsigned GPIOC_NSUB = 4;
	localparam int unsigned GPIOC_SUBW = 8;
	localparam int unsigned GPIOC_AW = 8;
	// ==========================================
	// Register map, byte addresses
	localparam logic [7:0] GPIOC_A_DIR = 8'h00;
	localparam logic [7:0] GPIOC_A_DIRCLR = 8'h04;
	localparam logic [7:0] GPIOC_A_DIRSET = 8'h08;
	localparam logic [7:0] GPIOC_A_DIRTGL = 8'h0c;
	localparam logic [7:0] GPIOC_A_OUT = 8'h10;
	localparam logic [7:0] GPIOC_A_LVLCLR = 8'h14;
	localparam logic [7:0] GPIOC_A_LVLSET = 8'h18;
	localparam logic [7:0] GPIOC_A_LVLTGL = 8'h1c;
	localparam logic [7:0] GPIOC_A_IN = 8'h20;
	localparam logic [7:0] GPIOC_A_CTRL = 8'h24;
	localparam logic [7:0] GPIOC_A_EVCTRL = 8'h28;
	localparam logic [7:0] GPIOC_A_INEN = 8'h2c;
	localparam logic [7:0] GPIOC_A_PULL = 8'h30;
	localparam logic [7:0] GPIOC_A_PMUX = 8'h34;
	localparam logic [7:0] GPIOC_A_ANALOG = 8'h38;
	localparam logic [7:0] GPIOC_A_DRV = 8'h3c;
	localparam logic [7:0] GPIOC_A_PONLY = 8'h40;
	localparam logic [7:0] GPIOC_A_DBG = 8'h44;
	// Family decode: addr[7:4] picks DIR or OUT, addr[3:2] the operation
	localparam logic [3:0] GPIOC_FAM_DIR = 4'h0;
	localparam logic [3:0] GPIOC_FAM_OUT = 4'h1;
	localparam logic [1:0] GPIOC_OP_WR = 2'h0;
	localparam logic [1:0] GPIOC_OP_CLR = 2'h1;
	localparam logic [1:0] GPIOC_OP_SET = 2'h2;
	localparam logic [1:0] GPIOC_OP_TGL = 2'h3;
	// ==========================================
	// Event control fields, one byte per event input
	localparam int unsigned GPIOC_EV_PID_LSB = 0;
	localparam int unsigned GPIOC_EV_PID_W = 5;
	localparam int unsigned GPIOC_EV_ACT_LSB = 5;
	localparam int unsigned GPIOC_EV_EN_BIT = 7;
	localparam int unsigned GPIOC_EV_W = 8;
	localparam logic [1:0] GPIOC_ACT_PASS = 2'h0;
	localparam logic [1:0] GPIOC_ACT_SET = 2'h1;
	localparam logic [1:0] GPIOC_ACT_CLR = 2'h2;
	localparam logic [1:0] GPIOC_ACT_TGL = 2'h3;
	// ==========================================
	// Responses, reset values, timing
	localparam logic [1:0] GPIOC_RESP_OKAY = 2'h0;
	localparam logic [1:0] GPIOC_RESP_SLVERR = 2'h2;
	localparam logic [31:0] GPIOC_RST32 = 32'h0000_0000;
	localparam logic [1:0] GPIOC_SYNC_WAIT = 2'h2;
	localparam logic [1:0] GPIOC_CNT_LAST = 2'h1;
	typedef enum logic [2:0] {
		GPIOC_RD_IDLE = 3'b001,
		GPIOC_RD_WAIT = 3'b010,
		GPIOC_RD_RESP = 3'b100
	} gpioc_rd_t;
endpackage

// file: core/gpioc_top.sv
// GPIO pin controller for one group of 32 lines, with AXI4-Lite registers.
// Assumes pads, event router and write guard sit outside; pad inputs are async.
// How it works
// RULE1: One group of up to 32 lines, each controllable alone or together.
// RULE2: One write sets, clears or toggles chosen direction or level bits only.
// RULE3: Each line is input or output with its own drive and pull settings.
// RULE4: Peripheral mux enabled: peripheral drives the pad and reads its level.
// RULE5: Under reset every line is input with input, output and pull off.
// RULE6: Backup sleep loses configuration but pads hold output level and pull.
// RULE7: Keeps working in any sleep mode while its clock runs; code holds its registers in reset during backup sleep.
// RULE8: Standby blocks configuration registers; data registers stay reachable.
// RULE9: Events and bus writes colliding get wait states; both complete.
// RULE10: Input synchronisers run on the main clock for least delay.
// RULE11: Registers sit on a divided, gateable bus clock; code clocks them on aclk like the synchronisers.
// RULE12: Four event inputs set, clear, toggle a level or pass to a pin.
// RULE13: Pass-through events are unsynchronised; router must use async path.
// RULE14: Keeps running in debug halt unless its debug halt control is set.
// RULE15: Write guard can block CPU writes to every writable register.
// RULE16: Guard lifted in debug halt and never applied to external debugger.
// RULE17: Analog function on a line turns off its digital input, output, pull.
// RULE18: Input buffer can switch off; pull-up or pull-down selectable.
// RULE19: Output is push-pull or pull-only, with selectable strength.
// RULE20: Direction one drives the level bit out; zero makes an input.
// RULE21: Strobe bit one sets, clears or inverts a level bit; zero does nothing.
// RULE22: Input read waits two cycles unless its 8-line subgroup samples always; code waits unless all four subgroups sample always.
// RULE23: Narrow writes touch only strobed byte lanes.
// RULE24: Unimplemented lines read zero and ignore direction and level writes.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module gpioc_top import gpioc_pkg::*; #(
	parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [GPIOC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [GPIOC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System state
	input wire logic standby_mode,
	input wire logic backup_mode,
	input wire logic cpu_debug_halt,
	input wire logic debugger_access,
	input wire logic write_guard_protect,
	// Event router inputs
	input wire logic [3:0] event_in,
	// Peripheral side
	input wire logic [31:0] periph_out,
	input wire logic [31:0] periph_oe,
	output logic [31:0] periph_in,
	// Pads
	input wire logic [31:0] pad_in,
	output logic [31:0] pad_out,
	output logic [31:0] pad_oe,
	output logic [31:0] pad_in_en,
	output logic [31:0] pad_pull_en,
	output logic [31:0] pad_pull_up,
	output logic [31:0] pad_drv_strong
);
	function automatic logic [31:0] gpioc_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [31:0] gpioc_upd(input logic [31:0] old,
		input logic [31:0] d, input logic [31:0] m, input logic [1:0] op);
		unique case (op)
			GPIOC_OP_WR: return (old & ~m) | (d & m);
			GPIOC_OP_CLR: return old & ~(d & m);
			GPIOC_OP_SET: return old | (d & m);
			default: return old ^ (d & m);
		endcase
	endfunction

	// ==========================================
	// Registers
	logic [31:0] dir_q, out_q, inen_q, pull_q, pmux_q, analog_q, drv_q, ponly_q;
	logic [31:0] evctl_q, in_q, sync1_q, sync2_q, rdata_q;
	logic [3:0] samp_q, ev1_q, ev2_q, ev3_q;
	logic dbgh_q;
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [GPIOC_AW-1:0] aw_addr_q, ar_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q, rcnt_q;
	gpioc_rd_t rd_q;
	logic [31:0] p_out_q, p_oe_q, p_ien_q, p_pull_q, p_up_q, p_drv_q;

	// ==========================================
	// Input synchronisers on the main clock
	always_ff @(posedge aclk) begin
		if (!aresetn || backup_mode) begin
			sync1_q <= GPIOC_RST32;
			sync2_q <= GPIOC_RST32;
		end else begin
			sync1_q <= pad_in; // RULE10
			sync2_q <= sync1_q;
		end
	end
	assign periph_in = sync2_q & pmux_q & ~analog_q; // RULE4

	// ==========================================
	// Events
	logic ev_halt, ev_any;
	logic [31:0] set_m, clr_m, tgl_m, pass_m, pass_v;
	logic [3:0] ev_rise;
	assign ev_halt = dbgh_q & cpu_debug_halt; // RULE14
	assign ev_rise = ev2_q & ~ev3_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev1_q <= 4'h0;
			ev2_q <= 4'h0;
			ev3_q <= 4'h0;
		end else begin
			ev1_q <= event_in;
			ev2_q <= ev1_q;
			ev3_q <= ev2_q;
		end
	end
	always_comb begin
		logic [7:0] f;
		logic [GPIOC_EV_PID_W-1:0] pid;
		logic [1:0] act;
		f = 8'h00;
		pid = '0;
		act = GPIOC_ACT_PASS;
		set_m = GPIOC_RST32;
		clr_m = GPIOC_RST32;
		tgl_m = GPIOC_RST32;
		pass_m = GPIOC_RST32;
		pass_v = GPIOC_RST32;
		for (int e = 0; e < GPIOC_NEV; e++) begin
			f = evctl_q[e*GPIOC_EV_W +: GPIOC_EV_W];
			pid = f[GPIOC_EV_PID_LSB +: GPIOC_EV_PID_W];
			act = f[GPIOC_EV_ACT_LSB +: 2];
			if (f[GPIOC_EV_EN_BIT] && !ev_halt) begin
				if (act == GPIOC_ACT_PASS) begin
					pass_m[pid] = 1'b1; // RULE13
					pass_v[pid] = event_in[e];
				end else if (ev_rise[e]) begin
					set_m[pid] = set_m[pid] | (act == GPIOC_ACT_SET); // RULE12
					clr_m[pid] = clr_m[pid] | (act == GPIOC_ACT_CLR);
					tgl_m[pid] = tgl_m[pid] | (act == GPIOC_ACT_TGL);
				end
			end
		end
	end
	assign ev_any = |((set_m | clr_m | tgl_m) & IMPL_MASK);

	// ==========================================
	// Write channel
	logic wr_do, wr_err, prot, is_cfg, fam_dir, fam_out;
	logic [31:0] wm;
	logic [1:0] wop;
	assign s_axi_awready = !aw_have_q && !bvalid_q; // RULE11
	assign s_axi_wready = !w_have_q && !bvalid_q; // RULE7
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	// Stalling on events costs one cycle but keeps level updates ordered
	assign wr_do = aw_have_q && w_have_q && !bvalid_q && !ev_any; // RULE9
	assign prot = write_guard_protect && !cpu_debug_halt && !debugger_access; // RULE16
	assign fam_dir = aw_addr_q[7:4] == GPIOC_FAM_DIR;
	assign fam_out = aw_addr_q[7:4] == GPIOC_FAM_OUT;
	assign wop = aw_addr_q[3:2];
	assign is_cfg = aw_addr_q >= GPIOC_A_CTRL && aw_addr_q <= GPIOC_A_DBG;
	assign wr_err = prot || (is_cfg && standby_mode) // RULE15 RULE8
		|| aw_addr_q[1:0] != 2'h0 || !(fam_dir || fam_out || is_cfg);
	assign wm = gpioc_mask(w_strb_q); // RULE23 RULE1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= GPIOC_RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= GPIOC_RST32;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_err ? GPIOC_RESP_SLVERR : GPIOC_RESP_OKAY;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Data registers
	logic wr_ok;
	assign wr_ok = wr_do && !wr_err;
	always_ff @(posedge aclk) begin
		if (!aresetn || backup_mode) begin
			dir_q <= GPIOC_RST32; // RULE5
			out_q <= GPIOC_RST32;
		end else begin
			if (wr_ok && fam_dir)
				dir_q <= gpioc_upd(dir_q, w_data_q, wm & IMPL_MASK, wop); // RULE2 RULE24
			if (wr_ok && fam_out)
				out_q <= gpioc_upd(out_q, w_data_q, wm & IMPL_MASK, wop); // RULE21
			else if (ev_any)
				out_q <= ((out_q | set_m) & ~clr_m ^ tgl_m) & IMPL_MASK; // RULE12
		end
	end

	// ==========================================
	// Configuration registers, lost in backup
	always_ff @(posedge aclk) begin
		if (!aresetn || backup_mode) begin
			inen_q <= GPIOC_RST32; // RULE5 RULE6
			pull_q <= GPIOC_RST32;
			pmux_q <= GPIOC_RST32;
			analog_q <= GPIOC_RST32;
			drv_q <= GPIOC_RST32;
			ponly_q <= GPIOC_RST32;
			evctl_q <= GPIOC_RST32;
			samp_q <= 4'h0;
			dbgh_q <= 1'b0;
		end else if (wr_ok && is_cfg) begin
			unique case (aw_addr_q)
				GPIOC_A_CTRL: samp_q <= (w_data_q[3:0] & wm[3:0]) | (samp_q & ~wm[3:0]);
				GPIOC_A_EVCTRL: evctl_q <= gpioc_upd(evctl_q, w_data_q, wm, GPIOC_OP_WR);
				GPIOC_A_INEN: inen_q <= gpioc_upd(inen_q, w_data_q, wm, GPIOC_OP_WR); // RULE18
				GPIOC_A_PULL: pull_q <= gpioc_upd(pull_q, w_data_q, wm, GPIOC_OP_WR);
				GPIOC_A_PMUX: pmux_q <= gpioc_upd(pmux_q, w_data_q, wm, GPIOC_OP_WR);
				GPIOC_A_ANALOG: analog_q <= gpioc_upd(analog_q, w_data_q, wm, GPIOC_OP_WR);
				GPIOC_A_DRV: drv_q <= gpioc_upd(drv_q, w_data_q, wm, GPIOC_OP_WR); // RULE19
				GPIOC_A_PONLY: ponly_q <= gpioc_upd(ponly_q, w_data_q, wm, GPIOC_OP_WR);
				default: dbgh_q <= (w_data_q[0] & wm[0]) | (dbgh_q & ~wm[0]);
			endcase
		end
	end

	// ==========================================
	// Pad drive, held by the pad latches during backup
	logic [31:0] drive, oe_d, out_d, pull_d;
	assign drive = dir_q & ~ponly_q; // RULE20 RULE19
	assign oe_d = (pmux_q & periph_oe) | (~pmux_q & drive);
	assign out_d = (pmux_q & periph_out) | (~pmux_q & out_q); // RULE4
	// Enabling the driver drops the pull; pull-only output turns it on
	assign pull_d = ~pmux_q & ((pull_q & ~dir_q) | (dir_q & ponly_q)); // RULE3
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p_out_q <= GPIOC_RST32; // RULE5
			p_oe_q <= GPIOC_RST32;
			p_ien_q <= GPIOC_RST32;
			p_pull_q <= GPIOC_RST32;
			p_up_q <= GPIOC_RST32;
			p_drv_q <= GPIOC_RST32;
		end else if (!backup_mode) begin // RULE6
			p_out_q <= out_d & ~analog_q & IMPL_MASK; // RULE17
			p_oe_q <= oe_d & ~analog_q & IMPL_MASK;
			p_ien_q <= (inen_q | pmux_q) & ~analog_q & IMPL_MASK;
			p_pull_q <= pull_d & ~analog_q & IMPL_MASK;
			p_up_q <= out_q & IMPL_MASK;
			p_drv_q <= drv_q & IMPL_MASK;
		end
	end
	logic [31:0] pm;
	assign pm = pass_m & ~analog_q & ~pmux_q & IMPL_MASK & {32{!backup_mode}};
	assign pad_out = (p_out_q & ~pm) | (pass_v & pm); // RULE13
	assign pad_oe = p_oe_q;
	assign pad_in_en = p_ien_q;
	assign pad_pull_en = p_pull_q;
	assign pad_pull_up = p_up_q;
	assign pad_drv_strong = p_drv_q;

	// ==========================================
	// Read channel
	logic [31:0] smask, rd_v, in_now;
	logic rd_err, rd_slow;
	assign smask = {{8{samp_q[3]}}, {8{samp_q[2]}}, {8{samp_q[1]}}, {8{samp_q[0]}}};
	assign in_now = ((sync2_q & ~smask) | (in_q & smask)) & inen_q & IMPL_MASK;
	assign s_axi_arready = rd_q == GPIOC_RD_IDLE;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign rd_slow = s_axi_araddr == GPIOC_A_IN && samp_q != 4'hf; // RULE22
	always_comb begin
		rd_err = standby_mode && s_axi_araddr >= GPIOC_A_CTRL; // RULE8
		unique case (s_axi_araddr)
			GPIOC_A_DIR, GPIOC_A_DIRCLR, GPIOC_A_DIRSET, GPIOC_A_DIRTGL: rd_v = dir_q;
			GPIOC_A_OUT, GPIOC_A_LVLCLR, GPIOC_A_LVLSET, GPIOC_A_LVLTGL: rd_v = out_q;
			GPIOC_A_IN: rd_v = in_q & inen_q & IMPL_MASK;
			GPIOC_A_CTRL: rd_v = {28'h0, samp_q};
			GPIOC_A_EVCTRL: rd_v = evctl_q;
			GPIOC_A_INEN: rd_v = inen_q;
			GPIOC_A_PULL: rd_v = pull_q;
			GPIOC_A_PMUX: rd_v = pmux_q;
			GPIOC_A_ANALOG: rd_v = analog_q;
			GPIOC_A_DRV: rd_v = drv_q;
			GPIOC_A_PONLY: rd_v = ponly_q;
			GPIOC_A_DBG: rd_v = {31'h0, dbgh_q};
			default: begin
				rd_v = GPIOC_RST32;
				rd_err = 1'b1;
			end
		endcase
		if (rd_err)
			rd_v = GPIOC_RST32;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || backup_mode) begin
			in_q <= GPIOC_RST32;
		end else if (rd_q == GPIOC_RD_WAIT && rcnt_q == GPIOC_CNT_LAST) begin
			in_q <= sync2_q; // RULE22
		end else begin
			in_q <= (sync2_q & smask) | (in_q & ~smask);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= GPIOC_RD_IDLE;
			rvalid_q <= 1'b0;
			rdata_q <= GPIOC_RST32;
			rresp_q <= GPIOC_RESP_OKAY;
			rcnt_q <= 2'h0;
			ar_addr_q <= '0;
		end else begin
			unique case (rd_q)
				GPIOC_RD_IDLE: if (s_axi_arvalid) begin
					ar_addr_q <= s_axi_araddr;
					rresp_q <= rd_err ? GPIOC_RESP_SLVERR : GPIOC_RESP_OKAY;
					rdata_q <= rd_v;
					if (rd_slow) begin
						rd_q <= GPIOC_RD_WAIT;
						rcnt_q <= GPIOC_SYNC_WAIT;
					end else begin
						rd_q <= GPIOC_RD_RESP;
						rvalid_q <= 1'b1;
					end
				end
				GPIOC_RD_WAIT: begin
					rcnt_q <= rcnt_q - GPIOC_CNT_LAST;
					if (rcnt_q == GPIOC_CNT_LAST) begin
						rdata_q <= in_now;
						rd_q <= GPIOC_RD_RESP;
						rvalid_q <= 1'b1;
					end
				end
				GPIOC_RD_RESP: if (s_axi_rready) begin
					rd_q <= GPIOC_RD_IDLE;
					rvalid_q <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// Checks
	a_reset_pads: assert property (@(posedge aclk) !aresetn |=> // RULE5
		(pad_oe | pad_in_en | pad_pull_en) == 32'h0) else $error("pads not off after reset");
	a_atomic_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
		wr_ok && aw_addr_q == GPIOC_A_LVLSET && !backup_mode |=>
		out_q == ($past(out_q) | ($past(w_data_q) & $past(wm) & IMPL_MASK)))
		else $error("set strobe wrong");
	a_event_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		ev_any && aw_have_q && w_have_q && !bvalid_q |=> !bvalid_q)
		else $error("write not stalled by event");
	a_guard_block: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
		wr_do && prot && !backup_mode && !ev_any |=> $stable(dir_q) ##0 bresp_q == GPIOC_RESP_SLVERR)
		else $error("guarded write not blocked");
	a_debug_lift: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
		wr_do && cpu_debug_halt && fam_dir && aw_addr_q[1:0] == 2'h0 |=>
		bresp_q == GPIOC_RESP_OKAY) else $error("guard not lifted in debug");
	a_standby_cfg: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
		wr_do && standby_mode && is_cfg |=> bresp_q == GPIOC_RESP_SLVERR)
		else $error("config written in standby");
	a_in_delay: assert property (@(posedge aclk) disable iff (!aresetn || backup_mode) // RULE22
		s_axi_arvalid && s_axi_arready && rd_slow |=> !rvalid_q ##1 !rvalid_q ##1 rvalid_q)
		else $error("input read delay not two");
	a_analog_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
		!backup_mode |=> (($past(analog_q)) & (p_oe_q | p_ien_q | p_pull_q)) == 32'h0)
		else $error("analog line still digital");
	a_backup_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		backup_mode |=> $stable(p_oe_q) && $stable(p_pull_q) && $stable(p_out_q))
		else $error("pad latch moved in backup");
	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE24
		((dir_q | out_q) & ~IMPL_MASK) == 32'h0) else $error("unimplemented line set");
endmodule

// file: bench/gpioc_pad_model.sv
// Pad model: resolves each pad's level from the controller and an outside driver.
// Assumes the bench drives ext_en/ext_val only on lines the controller leaves undriven.
`timescale 1ns/1ns
module gpioc_pad_model (
	// Clock
	input wire logic aclk,
	// Controller side
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe,
	input wire logic [31:0] pad_pull_en,
	input wire logic [31:0] pad_pull_up,
	// Outside driver
	input wire logic [31:0] ext_en,
	input wire logic [31:0] ext_val,
	// Level seen at the pads
	output logic [31:0] pad_in
);
	logic [31:0] wander_q = 32'h5555_5555;
	// A floating pad must never settle to a convenient value
	always @(posedge aclk) begin
		wander_q <= ~wander_q;
	end
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pad_pull_en[i]) begin
				pad_in[i] = pad_pull_up[i];
			end else begin
				pad_in[i] = wander_q[i];
			end
		end
	end
endmodule

// file: bench/gpioc_tb_top.sv
// Self-checking bench for the GPIO pin controller, with a reference model.
// Assumes the controller's package and the pad model are compiled first.
`timescale 1ns/1ns
module gpioc_tb_top import gpioc_pkg::*;;
	logic aclk = 0;
	logic aresetn = 0;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [3:0] ws = 0, ev = 0, s;
	logic stby = 0, bkup = 0, halt = 0, dbga = 0, prot = 0;
	logic [31:0] pout = 0, poe = 0, ext_en = 0, ext_val = 0;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] br, rr, r;
	logic [31:0] rd, pin, pdout, pdoe, pinen, ppen, ppup, pdrv, perin;
	logic [31:0] dir_m = 0, out_m = 0, d, v;
	int n_errors = 0, checked = 0, cyc = 0, seed = 62;

	gpioc_top uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.standby_mode(stby), .backup_mode(bkup), .cpu_debug_halt(halt),
		.debugger_access(dbga), .write_guard_protect(prot), .event_in(ev),
		.periph_out(pout), .periph_oe(poe), .periph_in(perin), .pad_in(pin),
		.pad_out(pdout), .pad_oe(pdoe), .pad_in_en(pinen), .pad_pull_en(ppen),
		.pad_pull_up(ppup), .pad_drv_strong(pdrv));
	gpioc_pad_model pads (.aclk(aclk), .pad_out(pdout), .pad_oe(pdoe), .pad_pull_en(ppen),
		.pad_pull_up(ppup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pin));

	// ==========================================
	// Clock, timeout, reporting
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] e);
		checked++;
		if (sn !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, sn);
		end
	endtask
	task give_verdict;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================
	// Bus master and model helpers
	task automatic wx(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] st,
		input logic [1:0] e);
		@(posedge aclk);
		awa <= a;
		wd <= dd;
		ws <= st;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
		end while (bv !== 1'b1);
		bry <= 0;
		chk("bresp", {30'h0, br}, {30'h0, e});
	endtask
	task automatic rx(input logic [7:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end while (rv !== 1'b1);
		v = rd;
		r = rr;
		rry <= 0;
	endtask
	function automatic logic [31:0] apply(input int op, input logic [31:0] c,
		input logic [31:0] dd, input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		case (op)
			0: return (c & ~m) | (dd & m);
			1: return c & ~(dd & m);
			2: return c | (dd & m);
			default: return c ^ (dd & m);
		endcase
	endfunction
	task automatic pulse;
		@(posedge aclk);
		ev <= 4'h1;
		repeat (2) @(posedge aclk);
		ev <= 4'h0;
		repeat (5) @(posedge aclk);
	endtask
	// ==========================================
	// Scenarios
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk("oe", pdoe, 32'h0);
		chk("inen", pinen | ppen, 32'h0);
		// Direction then level, every operation, random lanes
		for (int k = 0; k < 16; k++) begin
			d = $random(seed);
			s = 4'($random(seed));
			wx((k < 8 ? 8'h00 : 8'h10) + 8'((k % 4) * 4), d, s, GPIOC_RESP_OKAY);
			if (k < 8) dir_m = apply(k % 4, dir_m, d, s);
			else out_m = apply(k % 4, out_m, d, s);
			rx(k < 8 ? GPIOC_A_DIR : GPIOC_A_OUT);
			chk("readback", v, k < 8 ? dir_m : out_m);
			chk("pad_oe", pdoe, dir_m);
			chk("pad_out", pdout & dir_m, out_m & dir_m);
		end
		wx(8'h80, 32'hffff_ffff, 4'hf, GPIOC_RESP_SLVERR);
		wx(GPIOC_A_IN, 32'hffff_ffff, 4'hf, GPIOC_RESP_SLVERR);
		rx(8'h80);
		chk("unmapped", {r, v[29:0]}, {GPIOC_RESP_SLVERR, 30'h0});
		// Guard, lifted in debug halt and for the debugger
		prot <= 1;
		wx(GPIOC_A_DIRSET, 32'hffff_ffff, 4'hf, GPIOC_RESP_SLVERR);
		halt <= 1;
		wx(GPIOC_A_DIRCLR, 32'h0000_00ff, 4'hf, GPIOC_RESP_OKAY);
		halt <= 0;
		dbga <= 1;
		wx(GPIOC_A_DIRSET, 32'h0000_0f00, 4'hf, GPIOC_RESP_OKAY);
		dbga <= 0;
		prot <= 0;
		dir_m = (dir_m & ~32'hff) | 32'hf00;
		rx(GPIOC_A_DIR);
		chk("dir", v, dir_m);
		// Standby keeps data registers only
		stby <= 1;
		wx(GPIOC_A_PULL, 32'hffff_ffff, 4'hf, GPIOC_RESP_SLVERR);
		out_m = $random(seed);
		wx(GPIOC_A_OUT, out_m, 4'hf, GPIOC_RESP_OKAY);
		rx(GPIOC_A_PULL);
		chk("stby rresp", {30'h0, r}, {30'h0, GPIOC_RESP_SLVERR});
		stby <= 0;
		// Input path, on demand then continuous
		wx(GPIOC_A_DIR, 32'h0, 4'hf, GPIOC_RESP_OKAY);
		wx(GPIOC_A_INEN, 32'hffff_ffff, 4'hf, GPIOC_RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			wx(GPIOC_A_CTRL, k ? 32'hf : 32'h0, 4'hf, GPIOC_RESP_OKAY);
			ext_en <= 32'hffff_ffff;
			ext_val <= $random(seed);
			repeat (4) @(posedge aclk);
			rx(GPIOC_A_IN);
			chk("in", v, ext_val);
		end
		ext_en <= 32'h0;
		wx(GPIOC_A_PULL, 32'hffff_ffff, 4'hf, GPIOC_RESP_OKAY);
		@(posedge aclk);
		chk("pull_en", ppen, 32'hffff_ffff);
		chk("pull_up", ppup, out_m);
		d = $random(seed);
		wx(GPIOC_A_DRV, d, 4'hf, GPIOC_RESP_OKAY);
		wx(GPIOC_A_PONLY, 32'hffff_ffff, 4'hf, GPIOC_RESP_OKAY);
		dir_m = $random(seed);
		wx(GPIOC_A_DIR, dir_m, 4'hf, GPIOC_RESP_OKAY);
		@(posedge aclk);
		chk("pull only", pdoe | ~ppen, 32'h0);
		wx(GPIOC_A_PONLY, 32'h0, 4'hf, GPIOC_RESP_OKAY);
		@(posedge aclk);
		chk("drv", pdrv, d);
		chk("push pull", {pdoe, ppen & dir_m}, {dir_m, 32'h0});
		d = $random(seed);
		wx(GPIOC_A_ANALOG, d, 4'hf, GPIOC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("analog", (pdoe | pinen | ppen) & d, 32'h0);
		wx(GPIOC_A_ANALOG, 32'h0, 4'hf, GPIOC_RESP_OKAY);
		// Peripheral takes the pads
		wx(GPIOC_A_PMUX, 32'hffff_ffff, 4'hf, GPIOC_RESP_OKAY);
		pout <= $random(seed);
		poe <= $random(seed);
		ext_val <= $random(seed);
		@(posedge aclk);
		ext_en <= ~poe;
		repeat (5) @(posedge aclk);
		chk("periph drive", {pdout & poe, pdoe}, {pout & poe, poe});
		chk("periph in", perin & ~poe, ext_val & ~poe);
		ext_en <= 32'h0;
		wx(GPIOC_A_PMUX, 32'h0, 4'hf, GPIOC_RESP_OKAY);
		// Events on line 5
		wx(GPIOC_A_DIRSET, 32'h20, 4'hf, GPIOC_RESP_OKAY);
		for (int a = 1; a < 4; a++) begin
			wx(GPIOC_A_EVCTRL, {24'h0, 1'b1, 2'(a), 5'd5}, 4'hf, GPIOC_RESP_OKAY);
			pulse();
			out_m[5] = (a == 1) ? 1'b1 : (a == 2) ? 1'b0 : ~out_m[5];
			rx(GPIOC_A_OUT);
			chk("event", v, out_m);
		end
		// Collision of an event action with a bus write
		fork
			pulse();
			begin
				// One cycle late so the write lands on the event's action cycle
				@(posedge aclk);
				wx(GPIOC_A_LVLSET, 32'h1, 4'hf, GPIOC_RESP_OKAY);
			end
		join
		out_m = out_m ^ 32'h20 | 32'h1;
		rx(GPIOC_A_OUT);
		chk("collide", v, out_m);
		wx(GPIOC_A_DBG, 32'h1, 4'hf, GPIOC_RESP_OKAY);
		halt <= 1;
		pulse();
		halt <= 0;
		rx(GPIOC_A_OUT);
		chk("debug halt", v, out_m);
		wx(GPIOC_A_EVCTRL, {24'h0, 1'b1, GPIOC_ACT_PASS, 5'd5}, 4'hf, GPIOC_RESP_OKAY);
		@(posedge aclk);
		ev <= 4'h1;
		@(negedge aclk);
		chk("pass high", {31'h0, pdout[5]}, 32'h1);
		@(posedge aclk);
		ev <= 4'h0;
		@(negedge aclk);
		chk("pass low", {31'h0, pdout[5]}, 32'h0);
		// Backup sleep freezes the pads and loses the registers
		d = pdoe;
		v = pdout;
		@(posedge aclk);
		bkup <= 1;
		repeat (4) @(posedge aclk);
		chk("backup pads", pdoe ^ pdout, d ^ v);
		bkup <= 0;
		rx(GPIOC_A_DIR);
		chk("backup dir", v, 32'h0);
		give_verdict();
	end
endmodule
